//--- pkg/odt_zq_defines.vh
// Constants for the asynchronous termination and calibration block.
// Assumes the including file counts link times in command-clock cycles.
`ifndef ODT_ZQ_DEFINES_VH
`define ODT_ZQ_DEFINES_VH

// Own clock rate, in kHz
`define REF_CLK_KHZ 25000

// Asynchronous termination windows, in picoseconds
`define TAONPD_MIN_PS 2000
`define TAONPD_MAX_PS 8500
`define TAOFPD_MIN_PS 2000
`define TAOFPD_MAX_PS 8500

// Calibration periods, in command-clock cycles
`define TZQINIT_CK 512
`define TZQOPER_CK 256
`define TZQCS_CK 64

// Power-down and refresh windows, in command-clock cycles
`define TCPDED_CK 1
`define TRFC_CK 64
`define TXPDLL_CK 24

// Synchronous termination latency offset (WL minus this)
`define ODT_LAT_SUB 2

// Pin vector bit positions after synchronising
`define PIN_CLK 0
`define PIN_CKE 1
`define PIN_ODT 2
`define PIN_CS_N 3
`define PIN_RAS_N 4
`define PIN_CAS_N 5
`define PIN_WE_N 6
`define PIN_A10 7
`define PIN_ZQ 8
`define PIN_COUNT 9

// Mode register 0 bit A12 value that freezes the DLL in power-down
`define MR0_A12_FREEZE 1'h0

// Reset value of the calibration code (mid scale)
`define CAL_CODE_RESET 6'h20

`endif

//--- rtl/dram_odt_async_zq_calibration.v
// Termination timing (synchronous, asynchronous and transitions) and
// long/short calibration engine of the memory device.
// Assumes command pins and the command clock arrive from outside the
// ref_clk domain; config inputs and bank state come from ref_clk logic.
`timescale 1ns/1ps
`include "odt_zq_defines.vh"

module dram_odt_async_zq_calibration #(
	parameter LAT_W = 5,
	parameter CODE_W = 6,
	parameter CNT_W = 12,
	parameter [CNT_W-1:0] ZQINIT_CK = `TZQINIT_CK,
	parameter [CNT_W-1:0] ZQOPER_CK = `TZQOPER_CK,
	parameter [CNT_W-1:0] ZQCS_CK = `TZQCS_CK,
	parameter [CNT_W-1:0] CPDED_CK = `TCPDED_CK,
	parameter [CNT_W-1:0] RFC_CK = `TRFC_CK,
	parameter [CNT_W-1:0] XPDLL_CK = `TXPDLL_CK
) (
	input wire ref_clk, // Own clock, 25 MHz
	input wire rst_n, // Asynchronous reset, active low
	input wire cmd_clk, // Command clock pin, sampled
	input wire cke, // Clock enable pin
	input wire odt, // Termination request pin
	input wire cs_n, // Chip select pin, active low
	input wire ras_n, // Row strobe pin, active low
	input wire cas_n, // Column strobe pin, active low
	input wire we_n, // Write enable pin, active low
	input wire a10, // Address 10: long/short calibration select
	input wire zq_cmp, // Calibration comparator, high means step up
	input wire mr0_a12, // Mode register 0 bit A12, DLL kept in power-down
	input wire [3:0] cwl, // Write latency without additive part
	input wire [3:0] al, // Additive latency
	input wire all_banks_idle, // All banks precharged
	output reg rtt_en, // Termination applied
	output reg async_mode, // Asynchronous termination timing in use
	output reg odt_transition, // Inside an entry or exit window
	output reg zq_busy, // Calibration in progress
	output reg zq_current_en, // Calibration current path enabled
	output reg io_update, // One-cycle pulse: new codes applied
	output reg dq_hiz, // Data lines released by the device
	output reg [CODE_W-1:0] ron_code, // Driver strength code
	output reg [CODE_W-1:0] rtt_code // Termination strength code
);

	localparam DEPTH = 1 << LAT_W;
	localparam integer AON_INT =
		(`TAONPD_MIN_PS * `REF_CLK_KHZ + 999999999) / 1000000000;
	localparam integer AOF_INT =
		(`TAOFPD_MIN_PS * `REF_CLK_KHZ + 999999999) / 1000000000;
	localparam [3:0] AON_CYC = (AON_INT < 1) ? 4'h1 : AON_INT[3:0];
	localparam [3:0] AOF_CYC = (AOF_INT < 1) ? 4'h1 : AOF_INT[3:0];

	//////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	wire [`PIN_COUNT-1:0] pins;
	reg [`PIN_COUNT-1:0] pin_meta;
	reg [`PIN_COUNT-1:0] pin_sync;

	assign pins = {zq_cmp, a10, we_n, cas_n, ras_n, cs_n, odt, cke, cmd_clk};

	// Costs two own clocks on every pin, but all pins lag alike, so
	// the command and its qualifiers stay aligned to the clock edge
	// Two flops per pin; only the second stage is read
	genvar gi;
	generate
		for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_sync
			always @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_meta[gi] <= 1'h0;
					pin_sync[gi] <= 1'h0;
				end else begin
					pin_meta[gi] <= pins[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////
	// Command clock edge and command decode
	reg clk_prev;
	reg cke_q;
	wire ck_rise;
	wire s_cke;
	wire s_odt;
	wire cmd_sel;
	wire is_zq;
	wire is_ref;
	wire cke_fall;
	wire cke_rise;

	// All pins share one synchroniser latency, so setup is kept
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_prev <= 1'h0;
			cke_q <= 1'h0;
		end else begin
			clk_prev <= pin_sync[`PIN_CLK];
			if (ck_rise) begin
				cke_q <= pin_sync[`PIN_CKE];
			end
		end
	end

	assign ck_rise = pin_sync[`PIN_CLK] & ~clk_prev;
	assign s_cke = pin_sync[`PIN_CKE];
	assign s_odt = pin_sync[`PIN_ODT];
	assign cmd_sel = ck_rise & ~pin_sync[`PIN_CS_N];
	assign is_zq = cmd_sel & pin_sync[`PIN_RAS_N] & pin_sync[`PIN_CAS_N] &
		~pin_sync[`PIN_WE_N];
	assign is_ref = cmd_sel & ~pin_sync[`PIN_RAS_N] & ~pin_sync[`PIN_CAS_N] &
		pin_sync[`PIN_WE_N];
	assign cke_fall = ck_rise & cke_q & ~s_cke;
	assign cke_rise = ck_rise & ~cke_q & s_cke;

	//////////////////////////////////////////////////////////////////////
	// Refresh, self-refresh and power-down windows
	reg [CNT_W-1:0] ref_cnt;
	reg [CNT_W-1:0] ent_cnt;
	reg [CNT_W-1:0] exit_cnt;
	reg self_ref;
	reg pd_frozen;
	wire freeze_sel;
	wire in_window;
	wire use_async;

	assign freeze_sel = (mr0_a12 == `MR0_A12_FREEZE);
	assign in_window = (ent_cnt != {CNT_W{1'h0}}) |
		(exit_cnt != {CNT_W{1'h0}});
	assign use_async = pd_frozen | in_window;

	// A second refresh inside tRFC reloads the count, which only
	// lengthens the entry window and so stays on the safe side
	// Refresh remaining time, and self-refresh tracking
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt <= {CNT_W{1'h0}};
			self_ref <= 1'h0;
		end else if (ck_rise) begin
			if (is_ref && s_cke) begin
				ref_cnt <= RFC_CK;
			end else if (ref_cnt != {CNT_W{1'h0}}) begin
				ref_cnt <= ref_cnt - 1'h1;
			end
			if (is_ref && cke_fall) begin
				self_ref <= 1'h1;
			end else if (cke_rise) begin
				self_ref <= 1'h0;
			end
		end
	end

	// Entry/exit windows; a load of N covers N edges incl. end point
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ent_cnt <= {CNT_W{1'h0}};
			exit_cnt <= {CNT_W{1'h0}};
			pd_frozen <= 1'h0;
		end else if (ck_rise) begin
			if (cke_fall && freeze_sel && all_banks_idle && !is_ref) begin
				// End point included
				// This rise already counts toward the refresh, so the
				// window ends at the refresh end point, not one past it
				ent_cnt <= (ref_cnt > CPDED_CK + 1'h1) ?
					ref_cnt - 1'h1 : CPDED_CK;
				pd_frozen <= 1'h1;
			end else begin
				if (ent_cnt != {CNT_W{1'h0}}) begin
					ent_cnt <= ent_cnt - 1'h1;
				end
				if (cke_rise) begin
					pd_frozen <= 1'h0;
				end
			end
			// Only a frozen power-down has an exit window; active
			// power-down keeps synchronous timing throughout
			// Exit window lasts tXPDLL
			if (cke_rise && pd_frozen) begin
				exit_cnt <= XPDLL_CK;
			end else if (exit_cnt != {CNT_W{1'h0}}) begin
				exit_cnt <= exit_cnt - 1'h1;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Synchronous termination pipeline
	reg [DEPTH-1:0] odt_pipe;
	wire [LAT_W:0] wl_sum;
	wire [LAT_W:0] lat;
	wire sync_odt;
	localparam [LAT_W:0] LAT_SUB = `ODT_LAT_SUB;

	// Latency WL-2 with WL = CWL + AL
	// Stage 0 takes the level at the registering rise, so stage lat
	// holds it lat rises later; a latency below one is clamped
	assign wl_sum = {{(LAT_W-3){1'h0}}, cwl} + {{(LAT_W-3){1'h0}}, al};
	assign lat = (wl_sum > LAT_SUB) ? wl_sum - LAT_SUB :
		{{LAT_W{1'h0}}, 1'h1};
	assign sync_odt = odt_pipe[lat[LAT_W-1:0]];

	// One stage per command clock edge
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			odt_pipe <= {DEPTH{1'h0}};
		end else if (ck_rise) begin
			odt_pipe <= {odt_pipe[DEPTH-2:0], s_odt};
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Asynchronous termination path
	reg async_odt;
	reg [3:0] async_cnt;
	reg async_tgt;

	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			async_odt <= 1'h0;
			async_cnt <= 4'h0;
			async_tgt <= 1'h0;
		end else if (s_odt != async_tgt) begin
			// A new level restarts the wait
			async_tgt <= s_odt;
			async_cnt <= s_odt ? AON_CYC : AOF_CYC;
		end else if (async_cnt != 4'h0) begin
			async_cnt <= async_cnt - 4'h1;
			if (async_cnt == 4'h1) begin
				async_odt <= async_tgt;
			end
		end
	end

	// Termination output; inside windows the async path is used, which
	// lies within min of both minima and max of both maxima.
	// Pending sync changes are dropped on the switch; the async path
	// then follows the pin level within its own window.
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rtt_en <= 1'h0;
			async_mode <= 1'h0;
			odt_transition <= 1'h0;
		end else begin
			rtt_en <= use_async ? async_odt : sync_odt;
			async_mode <= use_async;
			odt_transition <= in_window;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Calibration engine
	reg [CNT_W-1:0] zq_cnt;
	reg first_done;
	reg [CODE_W-1:0] cal_code;
	wire zq_start;

	// A refused command leaves no trace; the controller must issue
	// it again once busy has fallen
	// Only an explicit command starts calibration
	assign zq_start = is_zq & cke_q & s_cke & ~self_ref & ~zq_busy;

	// Period select, up/down search, then transfer to the IO
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			zq_cnt <= {CNT_W{1'h0}};
			first_done <= 1'h0;
			cal_code <= `CAL_CODE_RESET;
			zq_busy <= 1'h0;
			zq_current_en <= 1'h0;
			io_update <= 1'h0;
			dq_hiz <= 1'h0;
			ron_code <= `CAL_CODE_RESET;
			rtt_code <= `CAL_CODE_RESET;
		end else begin
			io_update <= 1'h0;
			if (zq_start) begin
				if (pin_sync[`PIN_A10]) begin
					zq_cnt <= first_done ? ZQOPER_CK : ZQINIT_CK;
					first_done <= 1'h1;
				end else begin
					zq_cnt <= ZQCS_CK;
				end
				zq_busy <= 1'h1;
				zq_current_en <= 1'h1;
				dq_hiz <= 1'h1;
			end else if (zq_busy && ck_rise) begin
				// Saturating step so the code never wraps
				if (pin_sync[`PIN_ZQ] && cal_code != {CODE_W{1'h1}}) begin
					cal_code <= cal_code + 1'h1;
				end else if (!pin_sync[`PIN_ZQ] &&
					cal_code != {CODE_W{1'h0}}) begin
					cal_code <= cal_code - 1'h1;
				end
				zq_cnt <= zq_cnt - 1'h1;
				if (zq_cnt == {{(CNT_W-1){1'h0}}, 1'h1}) begin
					ron_code <= cal_code;
					rtt_code <= cal_code;
					io_update <= 1'h1;
					zq_busy <= 1'h0;
					zq_current_en <= 1'h0;
					dq_hiz <= 1'h0;
				end
			end
		end
	end

endmodule // dram_odt_async_zq_calibration

//--- tb/mem_ctrl_model.sv
// Controller model: free command clock, commands, CKE and ODT pins.
// Assumes the bench changes requests away from command clock falls.
`timescale 1ns/1ps
module mem_ctrl_model (
	input wire [1:0] cmd, // 0 none, 1 long, 2 short, 3 refresh
	input wire cke_req, // Wanted CKE level
	input wire odt_req, // Wanted ODT level
	output reg cmd_clk, // Command clock, 320 ns
	output reg cke, // Clock enable pin
	output reg odt, // Termination pin
	output reg cs_n, // Chip select, active low
	output reg ras_n, // Row strobe, active low
	output reg cas_n, // Column strobe, active low
	output reg we_n, // Write enable, active low
	output reg a10 // Long or short select
);
	initial {cmd_clk, cke, odt, cs_n, ras_n, cas_n, we_n, a10} = 8'h1E;
	// Command clock runs free, as on a real channel
	always #160 cmd_clk = ~cmd_clk;
	// Pins move at the falling edge so each rise sees settled values
	always @(negedge cmd_clk) begin
		cke <= cke_req;
		odt <= odt_req;
		if (cmd != 2'h0) begin
			{cs_n, ras_n, cas_n, we_n} <= (cmd == 2'h3) ? 4'h1 : 4'h6;
			a10 <= (cmd == 2'h1);
		end else begin
			// Deselected lines must not keep a stale command
			{cs_n, ras_n, cas_n, we_n} <= {1'b1, ~ras_n, ~cas_n, ~we_n};
			a10 <= ~a10;
		end
	end
endmodule // mem_ctrl_model

//--- tb/odt_zq_properties.sv
// Port checker for termination timing and calibration.
// Assumes the command clock is eight own clocks long.
`timescale 1ns/1ps
module odt_zq_properties #(
	parameter CODE_W = 6,
	parameter CNT_W = 12,
	parameter [CNT_W-1:0] ZQINIT_CK = 512,
	parameter [CNT_W-1:0] ZQCS_CK = 64
) (
	input wire ref_clk, // Own clock
	input wire rst_n, // Reset, active low
	input wire odt, // Termination pin
	input wire mr0_a12, // DLL kept in power-down
	input wire rtt_en, // Termination applied
	input wire async_mode, // Async timing in use
	input wire odt_transition, // Inside a window
	input wire zq_busy, // Calibrating
	input wire zq_current_en, // Current path on
	input wire io_update, // New codes pulse
	input wire dq_hiz, // Data lines released
	input wire [CODE_W-1:0] ron_code // Driver code
);
	localparam int LO = (ZQCS_CK - 1) * 8;
	localparam int HI = (ZQINIT_CK + 1) * 8;
	reg [15:0] busy_len;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////
	// Busy length in own clocks, cleared when idle
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_len <= 16'h0000;
		end else begin
			busy_len <= zq_busy ? busy_len + 16'h0001 : 16'h0000;
		end
	end
	current_eq_a:
	assert property (zq_current_en == zq_busy)
	else $error("current path differs from busy");
	hiz_busy_a:
	assert property (dq_hiz == zq_busy)
	else $error("data lines not released while busy");
	end_update_a:
	assert property ($fell(zq_busy) |-> io_update)
	else $error("busy ended without code update");
	update_pulse_a:
	assert property (io_update |=> !io_update && !zq_busy)
	else $error("update pulse too long");
	code_hold_a:
	assert property (!io_update |-> $stable(ron_code))
	else $error("code moved without update");
	busy_len_a:
	assert property ($fell(zq_busy) |-> busy_len >= LO && busy_len <= HI)
	else $error("calibration length out of range");
	freeze_sel_a:
	assert property ($rose(async_mode) |-> !mr0_a12)
	else $error("async timing with DLL kept");
	async_on_a:
	assert property (async_mode && !odt_transition && $rose(odt) |->
		!rtt_en [*2] ##[1:7] rtt_en)
	else $error("async turn-on out of window");
	async_off_a:
	assert property (async_mode && !odt_transition && $fell(odt) |->
		rtt_en [*2] ##[1:7] !rtt_en)
	else $error("async turn-off out of window");
	cal_done_c: cover property ($fell(zq_busy));
	async_entry_c: cover property ($rose(async_mode));
	window_c: cover property ($rose(odt_transition));
endmodule // odt_zq_properties
bind dram_odt_async_zq_calibration odt_zq_properties #(
	.CODE_W(CODE_W), .CNT_W(CNT_W), .ZQINIT_CK(ZQINIT_CK), .ZQCS_CK(ZQCS_CK)
) chk (.ref_clk(ref_clk), .rst_n(rst_n), .odt(odt), .mr0_a12(mr0_a12),
	.rtt_en(rtt_en), .async_mode(async_mode), .odt_transition(odt_transition),
	.zq_busy(zq_busy), .zq_current_en(zq_current_en), .io_update(io_update),
	.dq_hiz(dq_hiz), .ron_code(ron_code));

//--- tb/test_dram_odt_async_zq_calibration.sv
// Self-checking bench for termination timing and calibration.
// Assumes the controller model owns the command pins and clock.
`timescale 1ns/1ps
module test_dram_odt_async_zq_calibration;
	reg ref_clk = 1'b0;
	reg rst_n = 1'b0;
	reg mr0_a12 = 1'b1;
	reg [3:0] cwl = 4'h5;
	reg [3:0] al = 4'h0;
	reg zq_cmp = 1'b0;
	reg [1:0] cmd = 2'h0;
	reg cke_req = 1'b1;
	reg odt_req = 1'b0;
	reg banks_idle = 1'b1;
	integer seed = 97;
	integer n_mismatch = 0;
	integer comparisons = 0;
	integer cycles = 0;
	integer n;
	wire cmd_clk, cke, odt, cs_n, ras_n, cas_n, we_n, a10;
	wire rtt_en, async_mode, odt_transition, zq_busy, io_update;
	wire zq_current_en, dq_hiz;
	wire [5:0] ron_code, rtt_code;
	mem_ctrl_model ctrl (.cmd(cmd), .cke_req(cke_req), .odt_req(odt_req),
		.cmd_clk(cmd_clk), .cke(cke), .odt(odt), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .a10(a10));
	// Short counts keep the run brief
	dram_odt_async_zq_calibration #(.ZQINIT_CK(16), .ZQOPER_CK(8),
		.ZQCS_CK(4), .RFC_CK(4), .XPDLL_CK(3)) dut (.ref_clk(ref_clk),
		.rst_n(rst_n), .cmd_clk(cmd_clk), .cke(cke), .odt(odt), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .a10(a10), .zq_cmp(zq_cmp),
		.mr0_a12(mr0_a12), .cwl(cwl), .al(al), .all_banks_idle(banks_idle),
		.rtt_en(rtt_en), .async_mode(async_mode),
		.odt_transition(odt_transition), .zq_busy(zq_busy),
		.zq_current_en(zq_current_en), .io_update(io_update),
		.dq_hiz(dq_hiz),
		.ron_code(ron_code), .rtt_code(rtt_code));
	always #20 ref_clk = ~ref_clk;
	// Random comparator, and a cycle ceiling against hangs
	always @(posedge ref_clk) begin
		zq_cmp <= #1 ($random(seed) > 0);
		cycles = cycles + 1;
		if (cycles == 20000) begin
			n_mismatch = n_mismatch + 1;
			finish_test;
		end
	end
	////////////////////////////////////////////////////////////
	task check(input [15:0] got, input [15:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("[FAIL] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task finish_test;
		begin
			if (n_mismatch == 0 && comparisons > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	task issue(input [1:0] c);
		begin
			@(posedge cmd_clk) #1 cmd = c;
			@(posedge cmd_clk) #1 cmd = 2'h0;
		end
	endtask
	// Busy length counted in command clock rises
	task cal(input [1:0] c, input [15:0] exp);
		begin
			issue(c);
			// The command is seen a few own clocks after its rise
			@(posedge cmd_clk);
			check({zq_busy, zq_current_en, dq_hiz}, 16'h0007);
			n = 0;
			while (zq_busy === 1'b1 && n < 1000) begin
				n = n + 1;
				@(posedge cmd_clk);
			end
			check(n, exp);
			check({zq_current_en, dq_hiz}, 16'h0000);
		end
	endtask
	// Rises between ODT registered and termination following
	task lat(input v, input [15:0] exp);
		begin
			@(posedge cmd_clk) #1 odt_req = v;
			@(posedge cmd_clk);
			n = 0;
			@(posedge cmd_clk);
			while (rtt_en !== v && n < 40) begin
				n = n + 1;
				@(posedge cmd_clk);
			end
			check(n, exp);
		end
	endtask
	task win;
		begin
			n = 0;
			repeat (12) begin
				@(posedge cmd_clk);
				n = n + odt_transition;
			end
		end
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		check({zq_busy, rtt_en, ron_code}, 16'h0020);
		cal(2'h1, 16);
		cal(2'h1, 8);
		cal(2'h2, 4);
		check(ron_code, rtt_code);
		repeat (3) begin
			cwl = 4'h5 + {$random(seed)} % 4;
			al = {$random(seed)} % 3;
			lat(1'b1, cwl + al - 2);
			lat(1'b0, cwl + al - 2);
			// Let stale levels leave the pipeline before latency changes
			repeat (32) @(posedge cmd_clk);
		end
		// Frozen power-down with a large additive latency
		al = 4'h7;
		mr0_a12 = 1'b0;
		@(posedge cmd_clk) #1 cke_req = 1'b0;
		win;
		check(n, 1);
		check(async_mode, 1);
		@(posedge cmd_clk) #1 odt_req = 1'b1;
		repeat (2) @(posedge cmd_clk);
		check(rtt_en, 1);
		@(posedge cmd_clk) #1 odt_req = 1'b0;
		repeat (2) @(posedge cmd_clk);
		check(rtt_en, 0);
		@(posedge cmd_clk) #1 cke_req = 1'b1;
		win;
		check(n, 3);
		check(async_mode, 0);
		// Refresh still running when CKE drops
		issue(2'h3);
		cke_req = 1'b0;
		win;
		check(n, 3);
		// Calibration with CKE low is ignored
		issue(2'h2);
		repeat (2) @(posedge cmd_clk);
		check(zq_busy, 0);
		@(posedge cmd_clk) #1 cke_req = 1'b1;
		win;
		check(n, 3);
		// One-rise power-down: entry and exit windows run back to back
		@(posedge cmd_clk) #1 cke_req = 1'b0;
		@(posedge cmd_clk) #1 cke_req = 1'b1;
		win;
		check(n, 4);
		check(async_mode, 0);
		// Active power-down: banks open, timing stays synchronous
		banks_idle = 1'b0;
		@(posedge cmd_clk) #1 cke_req = 1'b0;
		win;
		check(n, 0);
		check(async_mode, 0);
		@(posedge cmd_clk) #1 cke_req = 1'b1;
		banks_idle = 1'b1;
		win;
		check(n, 0);
		// Self refresh: no recalibration until commanded
		@(posedge cmd_clk) #1 cmd = 2'h3;
		cke_req = 1'b0;
		@(posedge cmd_clk) #1 cmd = 2'h0;
		repeat (4) @(posedge cmd_clk);
		check(async_mode, 0);
		@(posedge cmd_clk) #1 cke_req = 1'b1;
		win;
		check(n, 0);
		check(zq_busy, 0);
		cal(2'h2, 4);
		finish_test;
	end
endmodule // test_dram_odt_async_zq_calibration
